//--- hdl/lft_pkg.sv
// Constants, identifier table and byte helpers shared by both link ends.
// Assumes a 50 MHz system clock and one single-wire bus between the ends.
`default_nettype none
package lft_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_HZ      = 50_000_000;
	localparam int BAUD        = 19200;
	localparam int BIT_CYC     = CLK_HZ / BAUD;
	localparam int BRK_TX_BITS = 13;
	localparam int BRK_RX_BITS = 11;
	localparam int DEL_BITS    = 1;
	localparam int STOP_BIT    = 9;
	localparam int LAST_DATA   = 8;
	localparam int TICK_US     = 500;
	localparam int TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
	localparam int FT_CHAR_US  = 500;
	localparam int FT_BASE_US  = 1000;
	localparam int BT_US       = 12000;
	localparam int BT_TICKS    = BT_US / TICK_US;
	localparam int MAX_LEN     = 8;

	typedef struct packed {
		logic [3:0] len;
		logic       cb;
	} lft_idinfo_s;

	// ********************************
	// Identifier table
	// ********************************
	// length and source lookup
	function automatic lft_idinfo_s lft_id_info(input logic [5:0] id);
		lft_idinfo_s r;
		r = '0;
		case (id) inside
			[6'h00:6'h07]: r = {4'h4, 1'b1};
			6'h08: r = {4'h3, 1'b1};
			[6'h0a:6'h0d]: r = {4'h2, 1'b0};
			6'h0e: r = {4'h4, 1'b1};
			6'h0f: r = {4'h6, 1'b1};
			6'h10: r = {4'h5, 1'b1};
			6'h11: r = {4'h1, 1'b0};
			[6'h12:6'h14]: r = {4'h5, 1'b1};
			[6'h15:6'h18]: r = {4'h6, 1'b1};
			6'h1b: r = {4'h4, 1'b1};
			6'h1c: r = {4'h8, 1'b1};
			6'h1d: r = {4'h7, 1'b1};
			6'h1e: r = {4'h8, 1'b1};
			6'h1f: r = {4'h2, 1'b1};
			6'h20: r = {4'h6, 1'b1};
			[6'h23:6'h24]: r = {4'h1, 1'b0};
			[6'h25:6'h26]: r = {4'h2, 1'b0};
			[6'h27:6'h28]: r = {4'h1, 1'b0};
			6'h29: r = {4'h3, 1'b1};
			6'h2a: r = {4'h8, 1'b0};
			6'h2b: r = {4'h1, 1'b0};
			default: r = '0;
		endcase
		return r;
	endfunction : lft_id_info

	function automatic logic [7:0] lft_pid(input logic [5:0] id);
		logic p0;
		logic p1;
		p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
		p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
		return {p1, p0, id};
	endfunction : lft_pid

	// end-around carry sum over id and data
	function automatic logic [7:0] lft_cks(input logic [7:0] pid, input logic [63:0] d, input logic [3:0] len);
		logic [8:0] s;
		s = {1'b0, pid};
		for (int i = 0; i < MAX_LEN; i++)
		begin
			if (4'(i) < len)
			begin
				s = 9'(s[7:0]) + 9'(d[i*8 +: 8]);
				s = 9'(s[7:0]) + 9'(s[8]);
			end
		end
		return ~s[7:0];
	endfunction : lft_cks

	// n chars incl. checksum, half-ms ticks
	function automatic logic [4:0] lft_ft_ticks(input logic [3:0] len);
		return 5'(((int'(len) + 1) * FT_CHAR_US + FT_BASE_US) / TICK_US);
	endfunction : lft_ft_ticks

endpackage : lft_pkg
`default_nettype wire

//--- hdl/lft_if.sv
// Single-wire bus joining the control box end and a node end.
// Both ends only pull low; the line is recessive high otherwise.
`timescale 1ns/1ps
`default_nettype none
interface lft_if;
	logic cb_do;
	logic cb_oe_n;
	logic nd_do;
	logic nd_oe_n;
	logic line;

	assign line = (cb_oe_n | cb_do) & (nd_oe_n | nd_do);

	modport ctrl (output cb_do, output cb_oe_n, input line);
	modport node (output nd_do, output nd_oe_n, input line);
endinterface : lft_if
`default_nettype wire

//--- hdl/lft_ctrl_end.sv
// Control box end: header master, responder for its own identifiers, frame and bus timers.
// Assumes lft_if carries the wire and the user holds rsp_data stable during a frame.
// Notes on behaviour
// - frame timer armed after break plus identifier
// - timer is n times half ms plus 1ms
// - expired timer abandons the current frame
// - bus timer restarts per char, 12ms timeout
// - bus timer may be left out
// - 19200 bit/s, slave within two percent
// - control box is the single header master
// - ids 0-3 four-byte reference status
// - ids 4-7 four-byte reference status
// - id 8 three bytes, id 9 silent
// - ids 10-13 two-byte handset inputs
// - id 14 four-byte set compare serial
// - id 15 six bytes, id 16 five
// - id 17 one-byte boot-load command
// - ids 18,19 five-byte slave references
// - handsets command on ids 37 and 38
// - key pressed reported on ids 39, 40
// - master controls the common reference
// - identifier byte: six bits plus parity
// - 13-bit break, delimiter, no sync byte
// - break aborts pending transmission, new frame
// - LSB first, modulo-255 checksum over id+data
`timescale 1ns/1ps
`default_nettype none
module lft_ctrl_end #(
	parameter int BIT_CYC      = lft_pkg::BIT_CYC,
	parameter int TICK_CYC     = lft_pkg::TICK_CYC,
	parameter bit BUS_TIMER_EN = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        rst,
	lft_if.ctrl              lnk,
	input  wire logic        hdr_req,
	input  wire logic [5:0]  hdr_id,
	output logic             hdr_rdy,
	input  wire logic [63:0] rsp_data,
	output logic             frame_done,
	output logic             frame_ok,
	output logic [5:0]       frame_id,
	output logic [3:0]       frame_len,
	output logic [63:0]      frame_data,
	output logic             frame_to,
	output logic             bus_to
);

	// ********************************
	// Constants and state
	// ********************************
	localparam logic [15:0] BC   = 16'(BIT_CYC);
	localparam logic [15:0] HC   = 16'(BIT_CYC / 2);
	localparam logic [15:0] TC   = 16'(TICK_CYC);
	localparam logic [15:0] BTX  = 16'(lft_pkg::BRK_TX_BITS * BIT_CYC);
	localparam logic [15:0] BRX  = 16'(lft_pkg::BRK_RX_BITS * BIT_CYC);
	localparam logic [15:0] DLC  = 16'(lft_pkg::DEL_BITS * BIT_CYC);
	localparam logic [3:0]  STB  = 4'(lft_pkg::STOP_BIT);
	localparam logic [3:0]  LDB  = 4'(lft_pkg::LAST_DATA);
	localparam logic [4:0]  BTT  = 5'(lft_pkg::BT_TICKS);

	typedef enum logic [2:0] {
		F_IDLE = 3'h1,
		F_PID  = 3'h2,
		F_RESP = 3'h4
	} lft_fs_e;

	typedef enum logic [3:0] {
		T_IDLE = 4'h1,
		T_BRK  = 4'h2,
		T_DEL  = 4'h4,
		T_BYTE = 4'h8
	} lft_ts_e;

	typedef struct packed {
		logic [2:0]  sy;
		logic        lv;
		logic [15:0] lo;
		logic        rb;
		logic [15:0] rc;
		logic [3:0]  rn;
		logic [7:0]  rs;
		lft_fs_e     fs;
		logic [5:0]  id;
		logic [3:0]  len;
		logic        own;
		logic [3:0]  ri;
		logic [63:0] buf_d;
		lft_ts_e     ts;
		logic [15:0] tc;
		logic [3:0]  tn;
		logic [9:0]  sh;
		logic [3:0]  ti;
		logic        dom;
		logic [5:0]  hid;
		logic [15:0] dv;
		logic [4:0]  ft;
		logic        fon;
		logic [4:0]  bt;
		logic        done;
		logic        ok;
		logic        fto;
		logic        bto;
	} lft_cb_s;

	localparam lft_cb_s ST_RST = '{sy: 3'h7, lv: 1'b1, fs: F_IDLE, ts: T_IDLE, default: '0};

	lft_cb_s            st_r;
	lft_cb_s            st_nxt;
	logic               tick;
	logic               brk;
	logic               rxv;
	logic               rxok;
	logic               kill;
	logic [7:0]         txb;
	lft_pkg::lft_idinfo_s info;

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		st_nxt = st_r;
		tick = 1'b0;
		brk = 1'b0;
		rxv = 1'b0;
		rxok = 1'b0;
		kill = 1'b0;
		txb = '0;
		info = lft_pkg::lft_id_info(st_r.rs[5:0]);
		st_nxt.done = 1'b0;
		st_nxt.fto = 1'b0;
		st_nxt.bto = 1'b0;

		// Line sampled through three flops, 2nd and 3rd must agree
		st_nxt.sy = {st_r.sy[1:0], lnk.line};
		if (st_r.sy[1] == st_r.sy[2])
			st_nxt.lv = st_r.sy[2];

		if (st_r.dv == TC - 16'h0001)
		begin
			st_nxt.dv = '0;
			tick = 1'b1;
		end
		else
			st_nxt.dv = st_r.dv + 16'h0001;

		// long dominant run marks a break
		if (st_r.lv)
			st_nxt.lo = '0;
		else if (st_r.lo != BRX)
		begin
			st_nxt.lo = st_r.lo + 16'h0001;
			brk = (st_r.lo == BRX - 16'h0001);
		end

		if (!st_r.rb)
		begin
			if (st_r.lv && !st_nxt.lv)
			begin
				st_nxt.rb = 1'b1;
				st_nxt.rc = HC;
				st_nxt.rn = '0;
			end
		end
		else if (st_r.rc != '0)
			st_nxt.rc = st_r.rc - 16'h0001;
		else
		begin
			st_nxt.rc = BC - 16'h0001;
			st_nxt.rn = st_r.rn + 4'h1;
			if (st_r.rn == '0 && st_r.lv)
				st_nxt.rb = 1'b0;
			else if (st_r.rn != '0 && st_r.rn <= LDB)
				st_nxt.rs = {st_r.lv, st_r.rs[7:1]};
			else if (st_r.rn == STB)
			begin
				st_nxt.rb = 1'b0;
				rxv = 1'b1;
				rxok = st_r.lv;
			end
		end
		if (brk)
			st_nxt.rb = 1'b0;

		// ********************************
		// Frame sequence
		// ********************************
		case (st_r.fs)
			F_IDLE:
				;
			F_PID:
				if (rxv)
				begin
					st_nxt.fs = F_IDLE;
					if (rxok && st_r.rs == lft_pkg::lft_pid(st_r.rs[5:0]) && info.len != '0)
					begin
						st_nxt.fs = F_RESP;
						st_nxt.id = st_r.rs[5:0];
						st_nxt.len = info.len;
						// arm only on a valid identifier
						st_nxt.ft = lft_pkg::lft_ft_ticks(info.len);
						st_nxt.fon = 1'b1;
						st_nxt.own = info.cb;
						st_nxt.ri = '0;
						st_nxt.ti = '0;
						st_nxt.buf_d = '0;
					end
				end
			F_RESP:
				if (rxv)
				begin
					if (!rxok)
						kill = 1'b1;
					else if (st_r.ri == st_r.len)
					begin
						st_nxt.fs = F_IDLE;
						st_nxt.fon = 1'b0;
						st_nxt.own = 1'b0;
						st_nxt.done = 1'b1;
						// checksum compared on the last char
						st_nxt.ok = (st_r.rs == lft_pkg::lft_cks(lft_pkg::lft_pid(st_r.id), st_r.buf_d, st_r.len));
					end
					else
					begin
						st_nxt.buf_d[{st_r.ri[2:0], 3'h0} +: 8] = st_r.rs;
						st_nxt.ri = st_r.ri + 4'h1;
					end
				end
			default:
				st_nxt.fs = F_IDLE;
		endcase

		// frame timer counts down on ticks
		if (st_r.fon && tick)
		begin
			st_nxt.ft = st_r.ft - 5'h01;
			if (st_r.ft == 5'h01)
			begin
				st_nxt.fto = 1'b1;
				kill = 1'b1;
			end
		end

		// ********************************
		// Transmitter
		// ********************************
		case (st_r.ts)
			T_IDLE:
				if (hdr_req && st_r.fs == F_IDLE)
				begin
					st_nxt.ts = T_BRK;
					st_nxt.tc = BTX - 16'h0001;
					st_nxt.dom = 1'b1;
					st_nxt.hid = hdr_id;
				end
				else if (st_r.own && st_r.fs == F_RESP && st_r.ti <= st_r.len)
				begin
					if (st_r.ti == st_r.len)
						txb = lft_pkg::lft_cks(lft_pkg::lft_pid(st_r.id), rsp_data, st_r.len);
					else
						txb = rsp_data[{st_r.ti[2:0], 3'h0} +: 8];
					st_nxt.ti = st_r.ti + 4'h1;
					st_nxt.ts = T_BYTE;
					st_nxt.sh = {1'b1, txb, 1'b0};
					st_nxt.tn = '0;
					st_nxt.tc = BC - 16'h0001;
					st_nxt.dom = 1'b1;
				end
			// 13 dominant bits, then delimiter, then id
			T_BRK:
				if (st_r.tc == '0)
				begin
					st_nxt.ts = T_DEL;
					st_nxt.tc = DLC - 16'h0001;
					st_nxt.dom = 1'b0;
				end
				else
					st_nxt.tc = st_r.tc - 16'h0001;
			T_DEL:
				if (st_r.tc == '0)
				begin
					st_nxt.ts = T_BYTE;
					st_nxt.sh = {1'b1, lft_pkg::lft_pid(st_r.hid), 1'b0};
					st_nxt.tn = '0;
					st_nxt.tc = BC - 16'h0001;
					st_nxt.dom = 1'b1;
				end
				else
					st_nxt.tc = st_r.tc - 16'h0001;
			T_BYTE:
				if (st_r.tc != '0)
					st_nxt.tc = st_r.tc - 16'h0001;
				else if (st_r.tn == STB)
				begin
					st_nxt.ts = T_IDLE;
					st_nxt.dom = 1'b0;
				end
				else
				begin
					st_nxt.tn = st_r.tn + 4'h1;
					st_nxt.sh = {1'b1, st_r.sh[9:1]};
					st_nxt.dom = ~st_r.sh[1];
					st_nxt.tc = BC - 16'h0001;
				end
			default:
				st_nxt.ts = T_IDLE;
		endcase

		// expiry or bad char drops the frame
		if (kill)
		begin
			st_nxt.fs = F_IDLE;
			st_nxt.fon = 1'b0;
			st_nxt.own = 1'b0;
			st_nxt.done = ~st_nxt.fto;
			st_nxt.ok = 1'b0;
		end
		// break restarts framing, stops response bytes
		if (brk)
		begin
			st_nxt.fs = F_PID;
			st_nxt.fon = 1'b0;
			st_nxt.own = 1'b0;
		end
		// Own break must survive its own detection
		if ((kill || brk) && st_r.ts == T_BYTE && st_r.fs == F_RESP)
		begin
			st_nxt.ts = T_IDLE;
			st_nxt.dom = 1'b0;
		end

		// any char restarts the bus timer
		if (BUS_TIMER_EN)
		begin
			if (rxv || brk)
				st_nxt.bt = '0;
			else if (tick && st_r.bt != BTT)
			begin
				st_nxt.bt = st_r.bt + 5'h01;
				st_nxt.bto = (st_r.bt == BTT - 5'h01);
			end
		end
	end

	// ********************************
	// State register and outputs
	// ********************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	assign hdr_rdy     = (st_r.ts == T_IDLE) && (st_r.fs == F_IDLE);
	assign lnk.cb_do   = 1'b0;
	assign lnk.cb_oe_n = ~st_r.dom;
	assign frame_done  = st_r.done;
	assign frame_ok    = st_r.ok;
	assign frame_id    = st_r.id;
	assign frame_len   = st_r.len;
	assign frame_data  = st_r.buf_d;
	assign frame_to    = st_r.fto;
	assign bus_to      = st_r.bto;

endmodule : lft_ctrl_end
`default_nettype wire

//--- hdl/lft_node_end.sv
// Slave node end: answers its own identifier, receives all other frames, keeps both timers.
// Assumes a control box end issues all headers over lft_if.
`timescale 1ns/1ps
`default_nettype none
module lft_node_end #(
	parameter int BIT_CYC  = lft_pkg::BIT_CYC,
	parameter int TICK_CYC = lft_pkg::TICK_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	lft_if.node              lnk,
	input  wire logic        rsp_valid,
	input  wire logic [5:0]  rsp_id,
	input  wire logic [63:0] rsp_data,
	output logic             frame_done,
	output logic             frame_ok,
	output logic [5:0]       frame_id,
	output logic [3:0]       frame_len,
	output logic [63:0]      frame_data,
	output logic             frame_to,
	output logic             bus_to
);

	// ********************************
	// Constants and state
	// ********************************
	localparam logic [15:0] BC  = 16'(BIT_CYC);
	localparam logic [15:0] HC  = 16'(BIT_CYC / 2);
	localparam logic [15:0] TC  = 16'(TICK_CYC);
	localparam logic [15:0] BRX = 16'(lft_pkg::BRK_RX_BITS * BIT_CYC);
	localparam logic [3:0]  STB = 4'(lft_pkg::STOP_BIT);
	localparam logic [3:0]  LDB = 4'(lft_pkg::LAST_DATA);
	localparam logic [4:0]  BTT = 5'(lft_pkg::BT_TICKS);

	typedef enum logic [2:0] {
		F_IDLE = 3'h1,
		F_PID  = 3'h2,
		F_RESP = 3'h4
	} lft_nfs_e;

	typedef struct packed {
		logic [2:0]  sy;
		logic        lv;
		logic [15:0] lo;
		logic        rb;
		logic [15:0] rc;
		logic [3:0]  rn;
		logic [7:0]  rs;
		lft_nfs_e    fs;
		logic [5:0]  id;
		logic [3:0]  len;
		logic        own;
		logic [3:0]  ri;
		logic [63:0] buf_d;
		logic        tb;
		logic [15:0] tc;
		logic [3:0]  tn;
		logic [9:0]  sh;
		logic [3:0]  ti;
		logic        dom;
		logic [15:0] dv;
		logic [4:0]  ft;
		logic        fon;
		logic [4:0]  bt;
		logic        done;
		logic        ok;
		logic        fto;
		logic        bto;
	} lft_nd_s;

	localparam lft_nd_s ST_RST = '{sy: 3'h7, lv: 1'b1, fs: F_IDLE, default: '0};

	lft_nd_s              st_r;
	lft_nd_s              st_nxt;
	logic                 tick;
	logic                 brk;
	logic                 rxv;
	logic                 rxok;
	logic                 kill;
	logic [7:0]           txb;
	lft_pkg::lft_idinfo_s info;

	always_comb
	begin
		st_nxt = st_r;
		tick = 1'b0;
		brk = 1'b0;
		rxv = 1'b0;
		rxok = 1'b0;
		kill = 1'b0;
		txb = '0;
		info = lft_pkg::lft_id_info(st_r.rs[5:0]);
		st_nxt.done = 1'b0;
		st_nxt.fto = 1'b0;
		st_nxt.bto = 1'b0;

		st_nxt.sy = {st_r.sy[1:0], lnk.line};
		if (st_r.sy[1] == st_r.sy[2])
			st_nxt.lv = st_r.sy[2];

		if (st_r.dv == TC - 16'h0001)
		begin
			st_nxt.dv = '0;
			tick = 1'b1;
		end
		else
			st_nxt.dv = st_r.dv + 16'h0001;

		// break found by dominant run length
		if (st_r.lv)
			st_nxt.lo = '0;
		else if (st_r.lo != BRX)
		begin
			st_nxt.lo = st_r.lo + 16'h0001;
			brk = (st_r.lo == BRX - 16'h0001);
		end

		if (!st_r.rb)
		begin
			if (st_r.lv && !st_nxt.lv)
			begin
				st_nxt.rb = 1'b1;
				st_nxt.rc = HC;
				st_nxt.rn = '0;
			end
		end
		else if (st_r.rc != '0)
			st_nxt.rc = st_r.rc - 16'h0001;
		else
		begin
			st_nxt.rc = BC - 16'h0001;
			st_nxt.rn = st_r.rn + 4'h1;
			if (st_r.rn == '0 && st_r.lv)
				st_nxt.rb = 1'b0;
			else if (st_r.rn != '0 && st_r.rn <= LDB)
				st_nxt.rs = {st_r.lv, st_r.rs[7:1]};
			else if (st_r.rn == STB)
			begin
				st_nxt.rb = 1'b0;
				rxv = 1'b1;
				rxok = st_r.lv;
			end
		end
		if (brk)
			st_nxt.rb = 1'b0;

		case (st_r.fs)
			F_IDLE:
				;
			F_PID:
				if (rxv)
				begin
					st_nxt.fs = F_IDLE;
					if (rxok && st_r.rs == lft_pkg::lft_pid(st_r.rs[5:0]) && info.len != '0)
					begin
						st_nxt.fs = F_RESP;
						st_nxt.id = st_r.rs[5:0];
						st_nxt.len = info.len;
						st_nxt.ft = lft_pkg::lft_ft_ticks(info.len);
						st_nxt.fon = 1'b1;
						// safety reports go out here too
						st_nxt.own = !info.cb && rsp_valid && rsp_id == st_r.rs[5:0];
						st_nxt.ri = '0;
						st_nxt.ti = '0;
						st_nxt.buf_d = '0;
					end
				end
			F_RESP:
				if (rxv)
				begin
					if (!rxok)
						kill = 1'b1;
					else if (st_r.ri == st_r.len)
					begin
						st_nxt.fs = F_IDLE;
						st_nxt.fon = 1'b0;
						st_nxt.own = 1'b0;
						st_nxt.done = 1'b1;
						st_nxt.ok = (st_r.rs == lft_pkg::lft_cks(lft_pkg::lft_pid(st_r.id), st_r.buf_d, st_r.len));
					end
					else
					begin
						st_nxt.buf_d[{st_r.ri[2:0], 3'h0} +: 8] = st_r.rs;
						st_nxt.ri = st_r.ri + 4'h1;
					end
				end
			default:
				st_nxt.fs = F_IDLE;
		endcase

		if (st_r.fon && tick)
		begin
			st_nxt.ft = st_r.ft - 5'h01;
			if (st_r.ft == 5'h01)
			begin
				st_nxt.fto = 1'b1;
				kill = 1'b1;
			end
		end

		// response bytes LSB first, checksum last
		if (!st_r.tb)
		begin
			if (st_r.own && st_r.fs == F_RESP && st_r.ti <= st_r.len)
			begin
				if (st_r.ti == st_r.len)
					txb = lft_pkg::lft_cks(lft_pkg::lft_pid(st_r.id), rsp_data, st_r.len);
				else
					txb = rsp_data[{st_r.ti[2:0], 3'h0} +: 8];
				st_nxt.ti = st_r.ti + 4'h1;
				st_nxt.tb = 1'b1;
				st_nxt.sh = {1'b1, txb, 1'b0};
				st_nxt.tn = '0;
				st_nxt.tc = BC - 16'h0001;
				st_nxt.dom = 1'b1;
			end
		end
		else if (st_r.tc != '0)
			st_nxt.tc = st_r.tc - 16'h0001;
		else if (st_r.tn == STB)
		begin
			st_nxt.tb = 1'b0;
			st_nxt.dom = 1'b0;
		end
		else
		begin
			st_nxt.tn = st_r.tn + 4'h1;
			st_nxt.sh = {1'b1, st_r.sh[9:1]};
			st_nxt.dom = ~st_r.sh[1];
			st_nxt.tc = BC - 16'h0001;
		end

		// abandon frame on expiry or bad char
		if (kill)
		begin
			st_nxt.fs = F_IDLE;
			st_nxt.done = ~st_nxt.fto;
			st_nxt.ok = 1'b0;
		end
		if (brk)
			st_nxt.fs = F_PID;
		if (kill || brk)
		begin
			st_nxt.fon = 1'b0;
			st_nxt.own = 1'b0;
			st_nxt.tb = 1'b0;
			st_nxt.dom = 1'b0;
		end

		if (rxv || brk)
			st_nxt.bt = '0;
		else if (tick && st_r.bt != BTT)
		begin
			st_nxt.bt = st_r.bt + 5'h01;
			st_nxt.bto = (st_r.bt == BTT - 5'h01);
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	assign lnk.nd_do   = 1'b0;
	assign lnk.nd_oe_n = ~st_r.dom;
	assign frame_done  = st_r.done;
	assign frame_ok    = st_r.ok;
	assign frame_id    = st_r.id;
	assign frame_len   = st_r.len;
	assign frame_data  = st_r.buf_d;
	assign frame_to    = st_r.fto;
	assign bus_to      = st_r.bto;

endmodule : lft_node_end
`default_nettype wire

//--- tb/lft_chk.sv
// Wire checker for the link between both ends.
// Assumes the bench passes its own bit time.
`timescale 1ns/1ps
`default_nettype none
module lft_chk #(
	parameter int BIT_CYC = lft_pkg::BIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cb_do,
	input wire logic cb_oe_n,
	input wire logic nd_do,
	input wire logic nd_oe_n,
	input wire logic line
);
	// ****
	// Run counters
	// ****
	localparam int BRK = lft_pkg::BRK_TX_BITS * BIT_CYC;
	localparam int DL1 = BIT_CYC;
	localparam int DL2 = 2 * BIT_CYC;
	int cb_lo_r;
	int cb_hi_r;
	int nd_lo_r;
	int nd_hi_r;

	// Idle after reset counts as a long high run
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cb_lo_r <= 0;
			nd_lo_r <= 0;
			cb_hi_r <= BRK;
			nd_hi_r <= BRK;
		end
		else
		begin
			cb_lo_r <= cb_oe_n ? 0 : cb_lo_r + 1;
			nd_lo_r <= nd_oe_n ? 0 : nd_lo_r + 1;
			cb_hi_r <= cb_oe_n ? cb_hi_r + 1 : 0;
			nd_hi_r <= nd_oe_n ? nd_hi_r + 1 : 0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_reset_line_free: assert property ($fell(rst) |-> cb_oe_n && nd_oe_n)
		else $error("line pulled during reset");
	chk_pull_only_drive: assert property ((cb_oe_n || !cb_do) && (nd_oe_n || !nd_do))
		else $error("end drives recessive level");
	chk_break_max_len: assert property (cb_lo_r <= BRK)
		else $error("dominant run beyond break");
	chk_ctrl_bit_grid: assert property ($rose(cb_oe_n) |-> cb_lo_r % BIT_CYC == 0)
		else $error("control end off bit grid");
	chk_node_bit_grid: assert property ($rose(nd_oe_n) && cb_oe_n |-> nd_lo_r % BIT_CYC == 0)
		else $error("node end off bit grid");
	chk_node_no_break: assert property (nd_lo_r <= 9 * BIT_CYC)
		else $error("node sends a break");
	chk_ctrl_stop_gap: assert property ($fell(cb_oe_n) |-> cb_hi_r >= BIT_CYC)
		else $error("control end stop too short");
	chk_node_stop_gap: assert property ($fell(nd_oe_n) |-> nd_hi_r >= BIT_CYC)
		else $error("node end stop too short");
	chk_quiet_in_break: assert property (cb_lo_r > 9 * BIT_CYC |-> nd_oe_n)
		else $error("node pulls during break");
	chk_id_after_delim: assert property ($rose(cb_oe_n) && cb_lo_r == BRK |-> ##[DL1:DL2] $fell(cb_oe_n))
		else $error("no identifier after delimiter");

	cov_break: cover property ($rose(cb_oe_n) && cb_lo_r == BRK);
	cov_node_answer: cover property ($fell(nd_oe_n));
	cov_long_idle: cover property (cb_hi_r > 20 * BRK);
endmodule : lft_chk
`default_nettype wire

//--- tb/lin_frame_timing_and_id_map_tb_top.sv
// Bench joining the control box end and a node end.
// Assumes package, interface, both ends and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module lin_frame_timing_and_id_map_tb_top;
	localparam int BC = 16;
	localparam int TC = 200;
	logic        clk, rst, hdr_req, hdr_rdy, n_val, cok, nok;
	logic        c_done, c_ok, c_fto, c_bto, n_done, n_ok, n_fto, n_bto;
	logic [5:0]  hdr_id, n_rid, c_id, n_id;
	logic [3:0]  c_len, n_len;
	logic [63:0] c_rsp, n_rsp, c_data, n_data, e, m;
	logic [8:0]  b;
	logic [7:0]  wq[$];
	int          mismatches, checks_done, cd, cf, cb, nd, nf, nb;
	logic [7:0]  pids[22] = '{8'h80, 8'hc1, 8'h42, 8'h03, 8'hc4, 8'h85, 8'h06, 8'h47, 8'h08, 8'h49,
		8'hca, 8'h8b, 8'h4c, 8'h0d, 8'h8e, 8'hcf, 8'h50, 8'h11, 8'h92, 8'hd3, 8'h25, 8'he7};
	logic [3:0]  lens[22] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h3, 4'h0,
		4'h2, 4'h2, 4'h2, 4'h2, 4'h4, 4'h6, 4'h5, 4'h1, 4'h5, 4'h5, 4'h2, 4'h1};

	lft_if u_lft_if ();
	lft_ctrl_end #(.BIT_CYC(BC), .TICK_CYC(TC)) u_lft_ctrl_end (.clk(clk), .rst(rst), .lnk(u_lft_if),
		.hdr_req(hdr_req), .hdr_id(hdr_id), .hdr_rdy(hdr_rdy), .rsp_data(c_rsp), .frame_done(c_done),
		.frame_ok(c_ok), .frame_id(c_id), .frame_len(c_len), .frame_data(c_data), .frame_to(c_fto), .bus_to(c_bto));
	lft_node_end #(.BIT_CYC(BC), .TICK_CYC(TC)) u_lft_node_end (.clk(clk), .rst(rst), .lnk(u_lft_if),
		.rsp_valid(n_val), .rsp_id(n_rid), .rsp_data(n_rsp), .frame_done(n_done),
		.frame_ok(n_ok), .frame_id(n_id), .frame_len(n_len), .frame_data(n_data), .frame_to(n_fto), .bus_to(n_bto));
	lft_chk #(.BIT_CYC(BC)) u_lft_chk (.clk(clk), .rst(rst), .cb_do(u_lft_if.cb_do), .cb_oe_n(u_lft_if.cb_oe_n),
		.nd_do(u_lft_if.nd_do), .nd_oe_n(u_lft_if.nd_oe_n), .line(u_lft_if.line));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****
	// Pulse counters and wire monitor
	// ****
	always @(posedge clk)
	begin
		cd += int'(c_done === 1'b1);
		nd += int'(n_done === 1'b1);
		cf += int'(c_fto === 1'b1);
		nf += int'(n_fto === 1'b1);
		cb += int'(c_bto === 1'b1);
		nb += int'(n_bto === 1'b1);
		if (c_done === 1'b1)
			cok = c_ok;
		if (n_done === 1'b1)
			nok = n_ok;
	end

	// Stop bit low means a break: start a new frame
	initial
	forever
	begin
		@(negedge u_lft_if.line);
		repeat (BC / 2) @(posedge clk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (BC) @(posedge clk);
			b[i] = u_lft_if.line;
		end
		if (b[8])
			wq.push_back(b[7:0]);
		else
		begin
			wq.delete();
			// Bounded so a stuck line cannot park the monitor
			for (int j = 0; j < 9000 && u_lft_if.line !== 1'b1; j++)
				@(posedge clk);
		end
	end

	task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
		checks_done++;
		if (s !== x)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	task automatic tmo(input int n);
		if (n >= 9000)
		begin
			mismatches++;
			wrap_up();
		end
	endtask : tmo

	task automatic hdr(input logic [5:0] id);
		int n;
		n = 0;
		hdr_req <= 1'b1;
		hdr_id <= id;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hdr_rdy !== 1'b1 && n < 9000);
		hdr_req <= 1'b0;
		tmo(n);
	endtask : hdr

	task automatic run(input logic [5:0] id, input int lim, output int n);
		{cd, nd, cf, nf, cb, nb} = '0;
		hdr(id);
		n = 0;
		while ((cd + cf == 0 || nd + nf == 0) && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		tmo(n);
	endtask : run

	function automatic logic [7:0] cks(input logic [7:0] p, input logic [63:0] d, input logic [3:0] l);
		logic [8:0] s;
		s = {1'b0, p};
		for (int k = 0; k < int'(l); k++)
		begin
			s = 9'(s[7:0]) + 9'(d[k*8 +: 8]);
			s = 9'(s[7:0]) + 9'(s[8]);
		end
		return ~s[7:0];
	endfunction : cks

	initial
	begin
		int n;
		logic [5:0] q;
		{rst, hdr_req, hdr_id, n_val, n_rid} = {1'b1, 1'b0, 6'h00, 1'b0, 6'h00};
		c_rsp = 64'h8877665544332211;
		n_rsp = 64'hf1e2d3c4b5a69788;
		{mismatches, checks_done} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Node-sourced id with the node silent
		run(6'h0a, 9000, n);
		chk("frame_to pulses", {cf[3:0], nf[3:0], cd[3:0], nd[3:0]}, 16'h1100);
		chk("timer span", 64'(n >= 4 * TC + 23 * BC && n <= 6 * TC + 30 * BC), 64'h1);
		$display("test frame timeout done");
		n_val <= 1'b1;
		for (int i = 0; i < 22; i++)
		begin
			// Last two entries are the handset command and safety ids
			q = (i < 20) ? 6'(i) : 6'(2 * i - 3);
			n_rid <= q;
			run(q, (lens[i] == 4'h0) ? 5 * TC : 9000, n);
			e = ((i >= 10 && i <= 13) || i == 17 || i >= 20) ? n_rsp : c_rsp;
			m = (64'h1 << (8 * lens[i])) - 64'h1;
			chk("wire id byte", wq[0], pids[i]);
			chk("wire byte count", wq.size(), (lens[i] == 4'h0) ? 1 : lens[i] + 2);
			if (lens[i] == 4'h0)
				chk("silent id events", {cd[3:0], nd[3:0], cf[3:0], nf[3:0]}, 16'h0);
			else
			begin
				chk("frame events", {cd[3:0], nd[3:0], cf[3:0], nf[3:0]}, 16'h1100);
				chk("ok and ids", {cok, nok, c_id, n_id}, {2'b11, q, q});
				chk("lengths", {c_len, n_len}, {lens[i], lens[i]});
				chk("ctrl data", c_data & m, e & m);
				chk("node data", n_data & m, e & m);
				if (i == 17)
					chk("boot-load byte", c_data[7:0], n_rsp[7:0]);
				if (i == 20)
					chk("handset command", c_data[15:0], n_rsp[15:0]);
				if (i == 21)
					chk("safety report", c_data[7:0], n_rsp[7:0]);
				chk("wire checksum", wq[lens[i] + 1], cks(pids[i], e, lens[i]));
				for (int k = 0; k < int'(lens[i]); k++)
					chk("wire data", wq[k + 1], e[k*8 +: 8]);
			end
		end
		$display("test identifier table done");
		{cd, nd, cf, nf, cb, nb} = '0;
		n = 0;
		while (cb + nb < 2 && n < 30 * TC)
		begin
			@(posedge clk);
			n++;
		end
		chk("bus_to pulses", {cb[3:0], nb[3:0]}, 8'h11);
		chk("bus timer span", 64'(n >= 22 * TC && n <= 25 * TC), 64'h1);
		$display("test bus timeout done");
		wrap_up();
	end
endmodule : lin_frame_timing_and_id_map_tb_top
`default_nettype wire
